/* File: hdl/cca_regs.svh */
// register offsets, flag positions and reset values of the core execution block
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH

`define CCA_IO_BASE 16'h0020
`define CCA_SPL_ADDR 16'h005D
`define CCA_SPH_ADDR 16'h005E
`define CCA_CORE_STATUS_FLAGS_ADDR 16'h005F
`define CCA_RESET_VEC 16'h0000
`define CCA_CORE_STATUS_FLAGS_RST 8'h00

`define CCA_FLAG_I 7
`define CCA_FLAG_T 6
`define CCA_FLAG_H 5
`define CCA_FLAG_S 4
`define CCA_FLAG_V 3
`define CCA_FLAG_N 2
`define CCA_FLAG_Z 1
`define CCA_FLAG_C 0

`endif

/* File: hdl/cca_pkg.sv */
// types shared by the core execution block
package cca_pkg;
  typedef enum logic [6:0] {
    ST_EXEC = 7'h01,
    ST_WORD2 = 7'h02,
    ST_LOAD = 7'h04,
    ST_PUSH2 = 7'h08,
    ST_RET1 = 7'h10,
    ST_RET2 = 7'h20,
    ST_LPM = 7'h40
  } cca_state_t;

  typedef enum logic [3:0] {
    OP_ARITH = 4'h0,
    OP_LOGIC = 4'h1,
    OP_LDI = 4'h2,
    OP_SUBI = 4'h3,
    OP_ANDI = 4'h4,
    OP_ORI = 4'h5,
    OP_UNARY = 4'h6,
    OP_IN = 4'h7,
    OP_OUT = 4'h8,
    OP_CTRL = 4'h9,
    OP_RJMP = 4'hA,
    OP_RCALL = 4'hB
  } cca_major_t;

  typedef enum logic [3:0] {
    UN_COM = 4'h0,
    UN_NEG = 4'h1,
    UN_INC = 4'h2,
    UN_DEC = 4'h3,
    UN_LSR = 4'h4,
    UN_BST = 4'h5,
    UN_BLD = 4'h6,
    UN_PUSH = 4'h7,
    UN_POP = 4'h8,
    UN_LD = 4'h9,
    UN_ST = 4'hA,
    UN_LPM = 4'hB,
    UN_LDS = 4'hC,
    UN_STS = 4'hD
  } cca_unary_t;

  typedef enum logic [3:0] {
    CT_SEI = 4'h0,
    CT_CLI = 4'h1,
    CT_RET = 4'h2,
    CT_RETURN_FROM_IRQ = 4'h3,
    CT_CALL = 4'h4,
    CT_SPM = 4'h5
  } cca_ctrl_t;

  typedef enum logic [1:0] {
    W2_LDS = 2'h0,
    W2_STS = 2'h1,
    W2_CALL = 2'h2
  } cca_word2_t;
endpackage

/* File: hdl/cca_regfile.sv */
// 32 x 8 working register file with three read ports and pointer views
`timescale 1ns/1ps
module cca_regfile
  import cca_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [4:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [4:0] raddr_a_in,
  input wire logic [4:0] raddr_b_in,
  input wire logic [4:0] raddr_c_in,
  output logic [7:0] rdata_a_out,
  output logic [7:0] rdata_b_out,
  output logic [7:0] rdata_c_out,
  output logic [15:0] ptr_x_out,
  output logic [15:0] ptr_y_out,
  output logic [15:0] ptr_z_out,
  output logic [15:0] pair0_out
);
  logic [7:0] regs_q [32];
  logic [7:0] regs_d [32];

  // reads are combinational so an ALU operation completes in one clock
  assign rdata_a_out = regs_q[raddr_a_in];
  assign rdata_b_out = regs_q[raddr_b_in];
  assign rdata_c_out = regs_q[raddr_c_in];
  assign ptr_x_out = {regs_q[27], regs_q[26]};
  assign ptr_y_out = {regs_q[29], regs_q[28]};
  assign ptr_z_out = {regs_q[31], regs_q[30]};
  assign pair0_out = {regs_q[1], regs_q[0]};

  for (genvar i = 0; i < 32; i++)
  begin : g_entry
    always_comb
    begin
      regs_d[i] = (we_in && waddr_in == 5'(i)) ? wdata_in : regs_q[i];
    end

    always_ff @(posedge sys_clk_in)
    begin
      if (!nrst_in)
        regs_q[i] <= 8'h00;
      else if (ce_in)
        regs_q[i] <= regs_d[i];
    end
  end
endmodule

/* File: hdl/cca_core.sv */
// execution core: fetch, decode, ALU with status flags, stack, interrupts, data space
`timescale 1ns/1ps
`include "cca_regs.svh"
module cca_core
  import cca_pkg::*;
#(
  parameter int IRQ_COUNT = 8,
  parameter int IRQ_W = 3,
  parameter logic [15:0] VEC_WORDS = 16'h0002,
  parameter logic [15:0] BOOT_START = 16'h1C00,
  parameter logic [15:0] RAM_END = 16'h04FF
)
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  output logic [15:0] pm_addr_out,
  input wire logic [15:0] pm_data_in,
  output logic pm_store_we_out,
  output logic [15:0] pm_store_addr_out,
  output logic [15:0] pm_store_data_out,
  output logic [15:0] ds_addr_out,
  output logic [7:0] ds_wdata_out,
  output logic ds_we_out,
  output logic ds_re_out,
  input wire logic [7:0] ds_rdata_in,
  input wire logic [IRQ_COUNT-1:0] irq_req_in,
  output logic irq_ack_out,
  output logic [IRQ_W-1:0] irq_ack_id_out,
  output logic [7:0] core_status_flags_out
);
  cca_state_t state_q, state_d;
  logic [15:0] fa_q, fa_d, sp_q, sp_d, jump_q, jump_d, ra_q, ra_d;
  logic [7:0] core_status_flags_q, core_status_flags_d, tmp_q, tmp_d;
  logic [4:0] dst_q, dst_d;
  cca_word2_t w2_q, w2_d;
  logic [15:0] ds_addr_q, ds_addr_d, pst_addr_q, pst_addr_d, pst_data_q, pst_data_d;
  logic [7:0] ds_wdata_q, ds_wdata_d;
  logic ds_we_q, ds_we_d, ds_re_q, ds_re_d, pst_we_q, pst_we_d, ack_q, ack_d;
  logic [IRQ_W-1:0] ack_id_q, ack_id_d, irq_sel;

  logic rf_we;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata, rf_a, rf_b, rf_c, ld_data;
  logic [15:0] ptr_x, ptr_y, ptr_z, pair0, ptr, io_addr, next_pc, rel_pc;
  logic wr_en, rd_en;
  logic [15:0] wr_addr, rd_a;
  logic [7:0] wr_data;
  logic [7:0] fl_new, fl_mask, opb, res;
  logic [8:0] wide;
  logic [4:0] nib;
  logic take_irq;

  wire logic [15:0] ins = pm_data_in;
  wire logic [4:0] d5 = ins[11:7];
  wire logic [4:0] r5 = ins[6:2];
  wire logic [4:0] di = {1'b1, ins[3:0]};
  wire logic [7:0] imm = ins[11:4];
  wire logic [3:0] sub = ins[6:3];
  wire logic [2:0] bsel = ins[2:0];

  cca_regfile u_rf (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .we_in(rf_we),
    .waddr_in(rf_waddr),
    .wdata_in(rf_wdata),
    .raddr_a_in((ins[15:12] >= 4'h3 && ins[15:12] <= 4'h5) ? di : d5),
    .raddr_b_in(r5),
    .raddr_c_in(ra_q[4:0]),
    .rdata_a_out(rf_a),
    .rdata_b_out(rf_b),
    .rdata_c_out(rf_c),
    .ptr_x_out(ptr_x),
    .ptr_y_out(ptr_y),
    .ptr_z_out(ptr_z),
    .pair0_out(pair0)
  );

  function automatic logic is_core_reg(input logic [15:0] a);
    return a == `CCA_CORE_STATUS_FLAGS_ADDR || a == `CCA_SPL_ADDR || a == `CCA_SPH_ADDR;
  endfunction

  // lowest index is the lowest vector address, so it wins
  always_comb
  begin
    irq_sel = '0;
    for (int k = IRQ_COUNT - 1; k >= 0; k--)
      if (irq_req_in[k])
        irq_sel = IRQ_W'(k);
  end

  assign take_irq = core_status_flags_q[`CCA_FLAG_I] && (|irq_req_in);
  assign next_pc = fa_q + 16'h0001;
  assign rel_pc = next_pc + {{4{ins[11]}}, ins[11:0]};
  assign io_addr = {10'h000, ins[5:0]} + `CCA_IO_BASE;
  assign ptr = (ins[1:0] == 2'h0) ? ptr_x : (ins[1:0] == 2'h1) ? ptr_y : ptr_z;

  // data read by a load one cycle after its address was issued
  always_comb
  begin
    if (ra_q < `CCA_IO_BASE)
      ld_data = rf_c;
    else if (ra_q == `CCA_CORE_STATUS_FLAGS_ADDR)
      ld_data = core_status_flags_q;
    else if (ra_q == `CCA_SPL_ADDR)
      ld_data = sp_q[7:0];
    else if (ra_q == `CCA_SPH_ADDR)
      ld_data = sp_q[15:8];
    else
      ld_data = ds_rdata_in;
  end

  always_comb
  begin
    state_d = state_q;
    fa_d = fa_q;
    sp_d = sp_q;
    core_status_flags_d = core_status_flags_q;
    jump_d = jump_q;
    tmp_d = tmp_q;
    ra_d = ra_q;
    dst_d = dst_q;
    w2_d = w2_q;
    ds_addr_d = ds_addr_q;
    ds_wdata_d = ds_wdata_q;
    ds_we_d = 1'b0;
    ds_re_d = 1'b0;
    pst_we_d = 1'b0;
    pst_addr_d = pst_addr_q;
    pst_data_d = pst_data_q;
    ack_d = 1'b0;
    ack_id_d = ack_id_q;
    rf_we = 1'b0;
    rf_waddr = d5;
    rf_wdata = 8'h00;
    wr_en = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 8'h00;
    rd_en = 1'b0;
    rd_a = 16'h0000;
    fl_mask = 8'h00;
    fl_new = 8'h00;
    opb = (ins[15:12] == 4'h0 || ins[15:12] == 4'h1) ? rf_b : imm;
    wide = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    unique case (state_q)
      ST_EXEC:
      begin
        if (take_irq)
        begin
          // current instruction is not executed; its address is the return address
          wr_en = 1'b1;
          wr_addr = sp_q;
          wr_data = fa_q[7:0];
          sp_d = sp_q - 16'h0001;
          tmp_d = fa_q[15:8];
          jump_d = 16'((32'(irq_sel) + 32'd1) * 32'(VEC_WORDS));
          core_status_flags_d[`CCA_FLAG_I] = 1'b0;
          ack_d = 1'b1;
          ack_id_d = irq_sel;
          state_d = ST_PUSH2;
        end
        else
        begin
          fa_d = next_pc;
          case (ins[15:12])
            OP_ARITH, OP_SUBI:
            begin
              if (ins[15:12] == OP_ARITH && !ins[1])
              begin
                wide = {1'b0, rf_a} + {1'b0, opb} + {8'h00, ins[0] & core_status_flags_q[`CCA_FLAG_C]};
                nib = {1'b0, rf_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, ins[0] & core_status_flags_q[`CCA_FLAG_C]};
                res = wide[7:0];
                fl_new[`CCA_FLAG_V] = (rf_a[7] & opb[7] & ~res[7]) | (~rf_a[7] & ~opb[7] & res[7]);
              end
              else
              begin
                wide = {1'b0, rf_a} - {1'b0, opb} - {8'h00, ins[0] & core_status_flags_q[`CCA_FLAG_C] & ins[15:12] == OP_ARITH};
                nib = {1'b0, rf_a[3:0]} - {1'b0, opb[3:0]} - {4'h0, ins[0] & core_status_flags_q[`CCA_FLAG_C] & !ins[12]};
                res = wide[7:0];
                fl_new[`CCA_FLAG_V] = (rf_a[7] & ~opb[7] & ~res[7]) | (~rf_a[7] & opb[7] & res[7]);
              end
              fl_new[`CCA_FLAG_C] = wide[8];
              fl_new[`CCA_FLAG_H] = nib[4];
              fl_mask = 8'h3F;
              rf_we = 1'b1;
              rf_waddr = (ins[15:12] == OP_SUBI) ? di : d5;
              rf_wdata = res;
            end
            OP_LOGIC, OP_ANDI, OP_ORI:
            begin
              if (ins[15:12] == OP_ANDI || (ins[15:12] == OP_LOGIC && ins[1:0] == 2'h0))
                res = rf_a & opb;
              else if (ins[15:12] == OP_ORI || ins[1:0] == 2'h1)
                res = rf_a | opb;
              else if (ins[1:0] == 2'h2)
                res = rf_a ^ opb;
              else
                res = opb;
              // move copies without touching flags
              fl_mask = (ins[15:12] == OP_LOGIC && ins[1:0] == 2'h3) ? 8'h00 : 8'h1E;
              rf_we = 1'b1;
              rf_waddr = (ins[15:12] == OP_LOGIC) ? d5 : di;
              rf_wdata = res;
            end
            OP_LDI:
            begin
              rf_we = 1'b1;
              rf_waddr = di;
              rf_wdata = imm;
            end
            OP_UNARY:
            begin
              case (sub)
                UN_COM, UN_NEG, UN_INC, UN_DEC, UN_LSR:
                begin
                  res = (sub == UN_COM) ? ~rf_a : (sub == UN_NEG) ? 8'h00 - rf_a :
                        (sub == UN_INC) ? rf_a + 8'h01 : (sub == UN_DEC) ? rf_a - 8'h01 : {1'b0, rf_a[7:1]};
                  fl_new[`CCA_FLAG_V] = (sub == UN_NEG) ? res == 8'h80 : (sub == UN_INC) ? res == 8'h80 :
                                        (sub == UN_DEC) ? res == 8'h7F : (sub == UN_LSR) ? rf_a[0] : 1'b0;
                  fl_new[`CCA_FLAG_C] = (sub == UN_COM) ? 1'b1 : (sub == UN_NEG) ? res != 8'h00 : rf_a[0];
                  fl_new[`CCA_FLAG_H] = res[3] | rf_a[3];
                  fl_mask = (sub == UN_INC || sub == UN_DEC) ? 8'h1E : (sub == UN_NEG) ? 8'h3F : 8'h1F;
                  rf_we = 1'b1;
                  rf_wdata = res;
                end
                UN_BST: core_status_flags_d[`CCA_FLAG_T] = rf_a[bsel];
                UN_BLD:
                begin
                  rf_we = 1'b1;
                  rf_wdata = rf_a;
                  rf_wdata[bsel] = core_status_flags_q[`CCA_FLAG_T];
                end
                UN_PUSH:
                begin
                  wr_en = 1'b1;
                  wr_addr = sp_q;
                  wr_data = rf_a;
                  sp_d = sp_q - 16'h0001;
                end
                UN_POP:
                begin
                  rd_en = 1'b1;
                  rd_a = sp_q + 16'h0001;
                  sp_d = sp_q + 16'h0001;
                end
                UN_LD:
                begin
                  rd_en = 1'b1;
                  rd_a = ptr;
                end
                UN_ST:
                begin
                  wr_en = 1'b1;
                  wr_addr = ptr;
                  wr_data = rf_a;
                end
                UN_LPM:
                begin
                  // fetch port is borrowed for one cycle to read the table word
                  jump_d = next_pc;
                  fa_d = {1'b0, ptr_z[15:1]};
                  ra_d = ptr_z;
                  dst_d = d5;
                  state_d = ST_LPM;
                end
                UN_LDS, UN_STS:
                begin
                  w2_d = (sub == UN_LDS) ? W2_LDS : W2_STS;
                  tmp_d = rf_a;
                  dst_d = d5;
                  state_d = ST_WORD2;
                end
                default:
                begin
                end
              endcase
            end
            OP_IN:
            begin
              rd_en = 1'b1;
              rd_a = io_addr;
            end
            OP_OUT:
            begin
              wr_en = 1'b1;
              wr_addr = io_addr;
              wr_data = rf_a;
            end
            OP_CTRL:
            begin
              case (ins[11:8])
                CT_SEI: core_status_flags_d[`CCA_FLAG_I] = 1'b1;
                CT_CLI: core_status_flags_d[`CCA_FLAG_I] = 1'b0;
                CT_RET, CT_RETURN_FROM_IRQ:
                begin
                  rd_en = 1'b1;
                  rd_a = sp_q + 16'h0001;
                  sp_d = sp_q + 16'h0001;
                  if (ins[8])
                    core_status_flags_d[`CCA_FLAG_I] = 1'b1;
                end
                CT_CALL:
                begin
                  w2_d = W2_CALL;
                  state_d = ST_WORD2;
                end
                CT_SPM:
                begin
                  pst_we_d = fa_q >= BOOT_START;
                  pst_addr_d = ptr_z;
                  pst_data_d = pair0;
                end
                default:
                begin
                end
              endcase
            end
            OP_RJMP: fa_d = rel_pc;
            OP_RCALL:
            begin
              wr_en = 1'b1;
              wr_addr = sp_q;
              wr_data = next_pc[7:0];
              sp_d = sp_q - 16'h0001;
              tmp_d = next_pc[15:8];
              jump_d = rel_pc;
              state_d = ST_PUSH2;
            end
            default:
            begin
            end
          endcase
          if (rd_en)
          begin
            dst_d = d5;
            state_d = (ins[15:12] == OP_CTRL) ? ST_RET1 : ST_LOAD;
          end
        end
      end
      ST_WORD2:
      begin
        fa_d = next_pc;
        unique case (w2_q)
          W2_LDS:
          begin
            rd_en = 1'b1;
            rd_a = ins;
            state_d = ST_LOAD;
          end
          W2_STS:
          begin
            wr_en = 1'b1;
            wr_addr = ins;
            wr_data = tmp_q;
            state_d = ST_EXEC;
          end
          W2_CALL:
          begin
            wr_en = 1'b1;
            wr_addr = sp_q;
            wr_data = next_pc[7:0];
            sp_d = sp_q - 16'h0001;
            tmp_d = next_pc[15:8];
            jump_d = ins;
            state_d = ST_PUSH2;
          end
        endcase
      end
      ST_PUSH2:
      begin
        wr_en = 1'b1;
        wr_addr = sp_q;
        wr_data = tmp_q;
        sp_d = sp_q - 16'h0001;
        fa_d = jump_q;
        state_d = ST_EXEC;
      end
      ST_LOAD:
      begin
        rf_we = 1'b1;
        rf_waddr = dst_q;
        rf_wdata = ld_data;
        state_d = ST_EXEC;
      end
      ST_RET1:
      begin
        tmp_d = ld_data;
        rd_en = 1'b1;
        rd_a = sp_q + 16'h0001;
        sp_d = sp_q + 16'h0001;
        state_d = ST_RET2;
      end
      ST_RET2:
      begin
        fa_d = {tmp_q, ld_data};
        state_d = ST_EXEC;
      end
      ST_LPM:
      begin
        rf_we = 1'b1;
        rf_waddr = dst_q;
        rf_wdata = ra_q[0] ? ins[15:8] : ins[7:0];
        fa_d = jump_q;
        state_d = ST_EXEC;
      end
    endcase
    // flags land with the write-back; sign always recomputed from N and V
    fl_new[`CCA_FLAG_N] = res[7];
    fl_new[`CCA_FLAG_Z] = res == 8'h00;
    fl_new[`CCA_FLAG_S] = fl_new[`CCA_FLAG_N] ^ fl_new[`CCA_FLAG_V];
    core_status_flags_d = (core_status_flags_d & ~fl_mask) | (fl_new & fl_mask);
    if (rd_en)
    begin
      ra_d = rd_a;
      ds_re_d = rd_a >= `CCA_IO_BASE && !is_core_reg(rd_a);
      ds_addr_d = rd_a;
    end
    if (wr_en)
    begin
      if (wr_addr < `CCA_IO_BASE)
      begin
        rf_we = 1'b1;
        rf_waddr = wr_addr[4:0];
        rf_wdata = wr_data;
      end
      else if (wr_addr == `CCA_CORE_STATUS_FLAGS_ADDR)
        core_status_flags_d = wr_data;
      else if (wr_addr == `CCA_SPL_ADDR)
        sp_d[7:0] = wr_data;
      else if (wr_addr == `CCA_SPH_ADDR)
        sp_d[15:8] = wr_data;
      else
      begin
        ds_we_d = 1'b1;
        ds_addr_d = wr_addr;
        ds_wdata_d = wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      state_q <= ST_EXEC;
      fa_q <= `CCA_RESET_VEC;
      sp_q <= RAM_END;
      core_status_flags_q <= `CCA_CORE_STATUS_FLAGS_RST;
      jump_q <= 16'h0000;
      tmp_q <= 8'h00;
      ra_q <= 16'h0000;
      dst_q <= 5'h00;
      w2_q <= W2_LDS;
      ds_addr_q <= 16'h0000;
      ds_wdata_q <= 8'h00;
      ds_we_q <= 1'b0;
      ds_re_q <= 1'b0;
      pst_we_q <= 1'b0;
      pst_addr_q <= 16'h0000;
      pst_data_q <= 16'h0000;
      ack_q <= 1'b0;
      ack_id_q <= '0;
    end
    else if (ce_in)
    begin
      state_q <= state_d;
      fa_q <= fa_d;
      sp_q <= sp_d;
      core_status_flags_q <= core_status_flags_d;
      jump_q <= jump_d;
      tmp_q <= tmp_d;
      ra_q <= ra_d;
      dst_q <= dst_d;
      w2_q <= w2_d;
      ds_addr_q <= ds_addr_d;
      ds_wdata_q <= ds_wdata_d;
      ds_we_q <= ds_we_d;
      ds_re_q <= ds_re_d;
      pst_we_q <= pst_we_d;
      pst_addr_q <= pst_addr_d;
      pst_data_q <= pst_data_d;
      ack_q <= ack_d;
      ack_id_q <= ack_id_d;
    end
  end

  assign pm_addr_out = fa_q;
  assign pm_store_we_out = pst_we_q;
  assign pm_store_addr_out = pst_addr_q;
  assign pm_store_data_out = pst_data_q;
  assign ds_addr_out = ds_addr_q;
  assign ds_wdata_out = ds_wdata_q;
  assign ds_we_out = ds_we_q;
  assign ds_re_out = ds_re_q;
  assign irq_ack_out = ack_q;
  assign irq_ack_id_out = ack_id_q;
  assign core_status_flags_out = core_status_flags_q;
endmodule

/* File: testbench/cca_core_sva.sv */
// assertion checker for the execution core ports
`timescale 1ns/1ps
module cca_core_sva
  import cca_pkg::*;
#(
  parameter int IRQ_COUNT = 8,
  parameter int IRQ_W = 3,
  parameter logic [15:0] VEC_WORDS = 16'h0002,
  parameter logic [15:0] BOOT_START = 16'h1C00
)
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [15:0] pm_addr_out,
  input wire logic pm_store_we_out,
  input wire logic [15:0] ds_addr_out,
  input wire logic ds_we_out,
  input wire logic ds_re_out,
  input wire logic [IRQ_COUNT-1:0] irq_req_in,
  input wire logic irq_ack_out,
  input wire logic [IRQ_W-1:0] irq_ack_id_out,
  input wire logic [7:0] core_status_flags_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  function automatic logic [IRQ_W-1:0] lowest(logic [IRQ_COUNT-1:0] req);
    lowest = '0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--)
      if (req[i])
        lowest = IRQ_W'(i);
  endfunction
  // return address goes out as two writes walking down the stack
  sequence s_push_pair;
    ds_we_out ##1 (ds_we_out && ds_addr_out == $past(ds_addr_out) - 16'h0001);
  endsequence
  property p_sign;
    core_status_flags_out[4] == (core_status_flags_out[2] ^ core_status_flags_out[3]);
  endproperty
  property p_ack_clears_i;
    irq_ack_out |-> !core_status_flags_out[7];
  endproperty
  property p_ack_needs_i;
    irq_ack_out |-> $past(core_status_flags_out[7]);
  endproperty
  property p_priority;
    irq_ack_out |-> irq_ack_id_out == lowest($past(irq_req_in));
  endproperty
  property p_irq_push;
    irq_ack_out |-> s_push_pair;
  endproperty
  property p_vector;
    irq_ack_out |=> pm_addr_out == (16'(irq_ack_id_out) + 16'h0001) * VEC_WORDS;
  endproperty
  property p_store_boot;
    pm_store_we_out |-> $past(pm_addr_out) >= BOOT_START;
  endproperty
  property p_ack_once;
    irq_ack_out |=> !irq_ack_out;
  endproperty
  property p_read_pulse;
    ds_re_out ##1 ds_re_out |=> !ds_re_out;
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag mismatch");
  a_ack_clears_i: assert property (p_ack_clears_i) else $error("enable kept on entry");
  a_ack_needs_i: assert property (p_ack_needs_i) else $error("entry while disabled");
  a_priority: assert property (p_priority) else $error("wrong source taken");
  a_irq_push: assert property (p_irq_push) else $error("bad return push");
  a_vector: assert property (p_vector) else $error("bad vector address");
  a_store_boot: assert property (p_store_boot) else $error("store outside boot");
  a_ack_once: assert property (p_ack_once) else $error("entry repeated");
  a_read_pulse: assert property (p_read_pulse) else $error("read strobe too long");
endmodule

/* File: testbench/cca_mem_model.sv */
// program and data memory seen by the core
`timescale 1ns/1ps
module cca_mem_model
(
  input wire logic sys_clk_in,
  input wire logic [15:0] pm_addr_in,
  output logic [15:0] pm_data_out,
  input wire logic [15:0] ds_addr_in,
  input wire logic [7:0] ds_wdata_in,
  input wire logic ds_we_in,
  input wire logic ds_re_in,
  output logic [7:0] ds_rdata_out
);
  logic [15:0] prog [0:511];
  logic [7:0] dmem [0:65535];
  initial
  begin
    for (int i = 0; i < 512; i++)
      prog[i] = 16'hC000;
  end
  assign pm_data_out = prog[pm_addr_in[8:0]];
  // the core takes read data in the cycle its strobe stands; inverted otherwise so a late sample shows
  assign ds_rdata_out = ds_re_in ? dmem[ds_addr_in] : ~dmem[ds_addr_in];
  always @(posedge sys_clk_in)
  begin
    if (ds_we_in)
      dmem[ds_addr_in] <= ds_wdata_in;
  end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the execution core
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
    end \
  end
module testbench;
  import cca_pkg::*;
  logic sys_clk_in, nrst_in, ce_in, pm_store_we_out, ds_we_out, ds_re_out, irq_ack_out;
  logic [15:0] pm_addr_out, pm_data_in, pm_store_addr_out, pm_store_data_out, ds_addr_out;
  logic [7:0] ds_wdata_out, ds_rdata_in, irq_req_in, core_status_flags_out, sr, res, va, vb;
  logic [2:0] irq_ack_id_out;
  logic [23:0] we;
  logic [23:0] expq [$];
  logic [31:0] rng = 32'h0001339D;
  int n_fail = 0, checks_done = 0, cyc = 0, n_spm = 0, pc, lo, n, lp;
  cca_core #(.BOOT_START(16'h0100)) cca_core_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .ce_in(ce_in), .pm_addr_out(pm_addr_out), .pm_data_in(pm_data_in), .pm_store_we_out(pm_store_we_out),
    .pm_store_addr_out(pm_store_addr_out), .pm_store_data_out(pm_store_data_out), .ds_addr_out(ds_addr_out),
    .ds_wdata_out(ds_wdata_out), .ds_we_out(ds_we_out), .ds_re_out(ds_re_out), .ds_rdata_in(ds_rdata_in),
    .irq_req_in(irq_req_in), .irq_ack_out(irq_ack_out), .irq_ack_id_out(irq_ack_id_out),
    .core_status_flags_out(core_status_flags_out));
  cca_mem_model cca_mem_model_inst (.sys_clk_in(sys_clk_in), .pm_addr_in(pm_addr_out), .pm_data_out(pm_data_in),
    .ds_addr_in(ds_addr_out), .ds_wdata_in(ds_wdata_out), .ds_we_in(ds_we_out), .ds_re_in(ds_re_out),
    .ds_rdata_out(ds_rdata_in));
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic put(logic [15:0] w);
    cca_mem_model_inst.prog[pc] = w;
    pc++;
  endtask
  task automatic expw(logic [15:0] a, logic [7:0] d);
    expq.push_back({a, d});
  endtask
  // reference flags: sbc zero is not chained, logic keeps carry and half carry
  task automatic alu(logic [3:0] m, logic [1:0] f, logic [7:0] a, logic [7:0] b);
    logic [8:0] w;
    logic c;
    c = f[0] && m == 4'h0 && sr[0];
    if (m == 4'h1)
    begin
      res = f == 2'h0 ? a & b : f == 2'h1 ? a | b : f == 2'h2 ? a ^ b : b;
      sr[3] = f == 2'h3 ? sr[3] : 1'b0;
    end
    else
    begin
      w = f[1] ? {1'b0, a} - b - c : {1'b0, a} + b + c;
      res = w[7:0];
      sr[0] = w[8];
      sr[5] = f[1] ? ({1'b0, a[3:0]} < {1'b0, b[3:0]} + c) : ({1'b0, a[3:0]} + b[3:0] + c > 5'h0F);
      sr[3] = (a[7] ^ b[7] ^ !f[1]) && (res[7] != a[7]);
    end
    if (!(m == 4'h1 && f == 2'h3))
      sr[4:1] = {res[7] ^ sr[3], sr[3], res[7], res == 8'h00};
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      print_verdict();
    end
    if (ds_we_out === 1'b1)
    begin
      we = expq.size() > 0 ? expq.pop_front() : 24'hxxxxxx;
      `CHK("write", we, {ds_addr_out, ds_wdata_out})
    end
    if (pm_store_we_out === 1'b1)
    begin
      n_spm++;
      `CHK("store", 16'h1234, pm_store_addr_out)
      `CHK("store data", 16'h0000, pm_store_data_out)
    end
  end
  initial
  begin
    nrst_in = 1'b0;
    ce_in = 1'b1;
    irq_req_in = 8'h00;
    sr = 8'h00;
    #1;
    pc = 0;
    put(16'hA01F);
    for (lo = 0; lo < 8; lo++)
    begin
      pc = 2 * lo + 2;
      put({4'h8, 5'd19, 1'b0, 6'(lo + 8)});
      put(16'h9300);
    end
    pc = 32;
    put(16'h25A3);
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 8; i++)
      begin
        va = r == 0 ? 8'hFF : r == 1 ? 8'h7F : rng[7:0];
        vb = r < 2 ? 8'h01 : rng[15:8];
        rng = xs(rng);
        put({4'h2, va, 4'h0});
        put({4'h2, vb, 4'h1});
        put({4'(i / 4), 5'd16, 5'd17, 2'(i)});
        put({4'h8, 5'd16, 7'h00});
        put({4'h7, 5'd18, 7'h3F});
        put({4'h8, 5'd18, 7'h01});
        alu(4'(i / 4), 2'(i), va, vb);
        expw(16'h0020, res);
        expw(16'h0021, sr);
      end
    put({4'h6, 5'd16, 7'h68});
    put(16'h0060);
    put({4'h6, 5'd22, 7'h60});
    put(16'h0060);
    put({4'h8, 5'd22, 7'h02});
    put(16'h6838);
    put(16'h6938);
    put(16'h6BC0);
    put(16'h6C40);
    put(16'h8B83);
    put(16'h8C04);
    put(16'h234E);
    put(16'h212F);
    put(16'h9500);
    lp = pc + 1;
    put({4'hB, 12'(255 - pc)});
    pc = pc + 4;
    put(16'h9000);
    lp = {lp[15:0], 16'(pc)};
    put(16'hAFFF);
    expw(16'h0060, res);
    expw(16'h0022, res);
    foreach (we[i])
      ;
    expw(16'h04FF, res);
    expw(16'h04FE, sr);
    expw(16'h0023, sr);
    expw(16'h0024, res);
    expw(16'h04FF, 8'(lp >> 16));
    expw(16'h04FE, 8'(lp >> 24));
    pc = 256;
    put(16'h9500);
    put(16'h9200);
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    n = 0;
    // requests during the masked part must all be ignored
    while (expq.size() > 0 && n < 1000)
    begin
      @(posedge sys_clk_in);
      irq_req_in <= rng[7:0];
      rng = xs(rng);
      n++;
    end
    irq_req_in <= 8'h00;
    sr[7] = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      va = rng[7:0] == 8'h00 ? 8'hC0 : rng[7:0];
      rng = xs(rng);
      for (int i = 7; i >= 0; i--)
        if (va[i])
          lo = i;
      expw(16'h04FF, 8'(lp));
      expw(16'h04FE, 8'(lp >> 8));
      expw(16'(40 + lo), 8'h5A);
      @(posedge sys_clk_in);
      irq_req_in <= va;
      n = 0;
      while (irq_ack_out !== 1'b1 && n < 40)
      begin
        @(posedge sys_clk_in);
        n++;
      end
      irq_req_in <= 8'h00;
      `CHK("source", 3'(lo), irq_ack_id_out)
      `CHK("entry flags", sr & 8'h7F, core_status_flags_out)
      repeat (12) @(posedge sys_clk_in);
      `CHK("return flags", sr, core_status_flags_out)
    end
    `CHK("stores", 1, n_spm)
    `CHK("pending", 0, expq.size())
    print_verdict();
  end
endmodule
bind cca_core cca_core_sva #(.IRQ_COUNT(IRQ_COUNT), .IRQ_W(IRQ_W), .VEC_WORDS(VEC_WORDS),
  .BOOT_START(BOOT_START)) cca_core_sva_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
  .pm_addr_out(pm_addr_out), .pm_store_we_out(pm_store_we_out), .ds_addr_out(ds_addr_out),
  .ds_we_out(ds_we_out), .ds_re_out(ds_re_out), .irq_req_in(irq_req_in), .irq_ack_out(irq_ack_out),
  .irq_ack_id_out(irq_ack_id_out), .core_status_flags_out(core_status_flags_out));
